//--- hw/sbs_map.svh
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// ------------------------------------------------------------
// Widths of the memory model
// ------------------------------------------------------------
`define SBS_AW 6
`define SBS_DW 32
`define SBS_PW 4
`define SBS_DEPTH 64
`define SBS_BURST_LEN 4
`define SBS_BURST_LAST 2'h3

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
// Clocks after reset before the strap synchroniser holds the pin value.
`define SBS_STRAP_SETTLE 2'h2
// Count loaded at the deselect strobe; the host then idles for one clock more than this.
`define SBS_DESEL_HOLD 3'h2

`endif

//--- hw/sbs_pkg.sv
package sbs_pkg;
  // Host sequencer states.
  typedef enum logic [2:0] {
    SBS_IDLE  = 3'b000,
    SBS_ADDR  = 3'b001,
    SBS_BURST = 3'b010,
    SBS_DESEL = 3'b011,
    SBS_DONE  = 3'b100
  } sbs_host_state_t;
endpackage

//--- hw/sbs_if.sv
`timescale 1ns/1ps
`include "sbs_map.svh"

// ------------------------------------------------------------
// Pins between the memory device and its controller
// ------------------------------------------------------------
interface sbs_if;
  logic [`SBS_AW-1:0] addr;
  logic first_select_n;
  logic second_select_hi;
  logic third_select_n;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic burst_advance_n;
  logic write_n;
  logic out_enable_n;
  logic sleep_request;
  logic [`SBS_DW-1:0] dev_data_o;
  logic [`SBS_PW-1:0] dev_par_o;
  logic dev_data_oe;
  logic [`SBS_DW-1:0] host_data_o;
  logic [`SBS_PW-1:0] host_par_o;
  logic host_data_oe;
  logic [`SBS_DW-1:0] data_lanes;
  logic [`SBS_PW-1:0] parity_lanes;

  // Wire resolution: whoever enables drives; idle bus reads as zero here.
  assign data_lanes = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '0);
  assign parity_lanes = dev_data_oe ? dev_par_o : (host_data_oe ? host_par_o : '0);

  modport device (
    input addr, first_select_n, second_select_hi, third_select_n, proc_addr_strobe_n,
    input ctrl_addr_strobe_n, burst_advance_n, write_n, out_enable_n, sleep_request,
    input data_lanes, parity_lanes,
    output dev_data_o, dev_par_o, dev_data_oe
  );
  modport host (
    output addr, first_select_n, second_select_hi, third_select_n, proc_addr_strobe_n,
    output ctrl_addr_strobe_n, burst_advance_n, write_n, out_enable_n, sleep_request,
    output host_data_o, host_par_o, host_data_oe,
    input data_lanes, parity_lanes
  );
endinterface

//--- hw/sbs_device.sv
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_device #(
  parameter bit BGA_PACKAGE = 1'b0
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic LINEAR_ORDER_N_I,
  output logic SELECTED_O,
  output logic SLEEPING_O,
  sbs_if.device PINS
);

  // ------------------------------------------------------------
  // Pin synchronisers for asynchronous inputs and the strap
  // ------------------------------------------------------------
  logic [1:0] oe_sync_q;
  logic [1:0] sleep_sync_q;
  logic [1:0] mode_sync_q;
  logic interleave_q;

  // Output enable and sleep are asynchronous, so they pass two flops.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      oe_sync_q <= 2'h3;
      sleep_sync_q <= 2'h0;
      mode_sync_q <= 2'h3;
    end else begin
      oe_sync_q <= {oe_sync_q[0], PINS.out_enable_n};
      sleep_sync_q <= {sleep_sync_q[0], PINS.sleep_request};
      mode_sync_q <= {mode_sync_q[0], LINEAR_ORDER_N_I};
    end
  end

  // The strap is static, so it is latched once and kept; the wait lets the
  // synchroniser hold the pin value rather than its own reset value.
  logic strap_taken_q;
  logic [1:0] strap_wait_q;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strap_taken_q <= 1'b0;
      strap_wait_q <= 2'h0;
      interleave_q <= 1'b1;
    end else if (!strap_taken_q) begin
      if (strap_wait_q == `SBS_STRAP_SETTLE) begin
        strap_taken_q <= 1'b1;
        interleave_q <= mode_sync_q[1];
      end else begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Strobe decode
  // ------------------------------------------------------------
  logic sleep;
  logic third_ok;
  logic all_sel;
  logic use_proc;
  logic use_ctrl;
  logic load;
  logic advance;

  assign sleep = sleep_sync_q[1];
  assign third_ok = BGA_PACKAGE ? 1'b1 : !PINS.third_select_n;
  assign all_sel = !PINS.first_select_n && PINS.second_select_hi && third_ok;
  // Processor strobe counts only while first select is low.
  assign use_proc = !PINS.proc_addr_strobe_n && !PINS.first_select_n && !sleep;
  // A processor strobe that is ignored lets the controller strobe stand alone.
  assign use_ctrl = !PINS.ctrl_addr_strobe_n && !use_proc && !sleep;
  assign load = use_proc || use_ctrl;
  assign advance = !load && !PINS.burst_advance_n && !sleep;

  // ------------------------------------------------------------
  // Address, burst counter and select registers
  // ------------------------------------------------------------
  logic [`SBS_AW-1:0] base_q;
  logic [1:0] cnt_q;
  logic sel_q;
  logic wr_q;
  logic [1:0] low_bits;
  logic [`SBS_AW-1:0] cur_addr;

  // Selects are only sampled with a new address; bursts keep the old value.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      base_q <= '0;
      cnt_q <= 2'h0;
      sel_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (load) begin
      base_q <= PINS.addr;
      cnt_q <= 2'h0;
      sel_q <= all_sel;
      wr_q <= !PINS.write_n;
    end else if (advance && sel_q) begin
      cnt_q <= cnt_q + 2'h1;
      wr_q <= !PINS.write_n;
    end
  end

  // Burst order: xor for interleaved, modulo-four add for linear.
  assign low_bits = interleave_q ? (base_q[1:0] ^ cnt_q) : (base_q[1:0] + cnt_q);
  assign cur_addr = {base_q[`SBS_AW-1:2], low_bits};

  // ------------------------------------------------------------
  // Storage array and pipelined read
  // ------------------------------------------------------------
  logic [`SBS_DW+`SBS_PW-1:0] mem_q [`SBS_DEPTH];
  logic [`SBS_DW+`SBS_PW-1:0] wdata_q;
  logic [`SBS_AW-1:0] waddr_q;
  logic wvalid_q;
  logic [`SBS_DW+`SBS_PW-1:0] rdata_q;

  // Write data is registered on the edge, then stored a cycle later.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wdata_q <= '0;
      waddr_q <= '0;
      wvalid_q <= 1'b0;
    end else begin
      wdata_q <= {PINS.parity_lanes, PINS.data_lanes};
      waddr_q <= cur_addr;
      wvalid_q <= sel_q && wr_q && !sleep;
    end
  end

  // Memory has no reset, so contents survive sleep and reset alike.
  always_ff @(posedge MCLK_I) begin
    if (wvalid_q) begin
      mem_q[waddr_q] <= wdata_q;
    end
  end

  // Read output register: one stage after address capture.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_q <= '0;
    end else if (sel_q && !wr_q) begin
      rdata_q <= mem_q[cur_addr];
    end
  end

  // ------------------------------------------------------------
  // Output drive control with double-cycle deselect
  // ------------------------------------------------------------
  logic sel_d1_q;
  logic mask_q;
  logic drive_q;
  logic rd_valid;

  assign rd_valid = sel_q && !wr_q;

  // Pipelined enable: the first read clock after a non-read clock, such as a deselect, is masked and not driven.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_d1_q <= 1'b0;
      mask_q <= 1'b1;
    end else begin
      sel_d1_q <= rd_valid;
      mask_q <= rd_valid && !sel_d1_q;
    end
  end

  // Drive only for a read out of the pipeline and with output enable low.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      drive_q <= 1'b0;
    end else begin
      // Drive follows the read register, so the word loaded on the deselect edge
      // still stands until the next rise and is released right after it.
      drive_q <= rd_valid && !sleep;
    end
  end

  // Output enable is asynchronous at the pin; it is synchronised here, a
  // trade of two cycles of latency for a single-clock design.
  assign PINS.dev_data_oe = drive_q && !oe_sync_q[1] && !mask_q;
  assign PINS.dev_data_o = rdata_q[`SBS_DW-1:0];
  assign PINS.dev_par_o = rdata_q[`SBS_DW+`SBS_PW-1:`SBS_DW];

  // Status flags for the user side.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SELECTED_O <= 1'b0;
      SLEEPING_O <= 1'b0;
    end else begin
      SELECTED_O <= sel_q;
      SLEEPING_O <= sleep;
    end
  end

endmodule

//--- hw/sbs_host.sv
`timescale 1ns/1ps
`include "sbs_map.svh"

// Controller end: issues one four-beat burst read or write per request.
module sbs_host (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic REQ_I,
  input wire logic WRITE_I,
  input wire logic USE_CTRL_STROBE_I,
  input wire logic [`SBS_AW-1:0] ADDR_I,
  input wire logic [`SBS_DW-1:0] WDATA_I,
  output logic BUSY_O,
  output logic RVALID_O,
  output logic [`SBS_DW-1:0] RDATA_O,
  sbs_if.host PINS
);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  sbs_pkg::sbs_host_state_t state_q;
  logic [1:0] beat_q;
  logic wr_q;
  logic [`SBS_DW-1:0] wdata_q;
  logic [2:0] rd_cnt_q;

  // Static pins: sleep tied low, third select active.
  assign PINS.sleep_request = 1'b0;
  assign PINS.third_select_n = 1'b0;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= sbs_pkg::SBS_IDLE;
      beat_q <= 2'h0;
      wr_q <= 1'b0;
      wdata_q <= '0;
      PINS.addr <= '0;
      PINS.first_select_n <= 1'b1;
      PINS.second_select_hi <= 1'b0;
      PINS.proc_addr_strobe_n <= 1'b1;
      PINS.ctrl_addr_strobe_n <= 1'b1;
      PINS.burst_advance_n <= 1'b1;
      PINS.write_n <= 1'b1;
      PINS.out_enable_n <= 1'b1;
      PINS.host_data_oe <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      unique case (state_q)
        sbs_pkg::SBS_IDLE: begin
          PINS.host_data_oe <= 1'b0;
          if (REQ_I) begin
            state_q <= sbs_pkg::SBS_BURST;
            BUSY_O <= 1'b1;
            wr_q <= WRITE_I;
            wdata_q <= WDATA_I;
            beat_q <= 2'h0;
            PINS.addr <= ADDR_I;
            PINS.first_select_n <= 1'b0;
            PINS.second_select_hi <= 1'b1;
            PINS.proc_addr_strobe_n <= USE_CTRL_STROBE_I;
            PINS.ctrl_addr_strobe_n <= !USE_CTRL_STROBE_I;
            PINS.write_n <= !WRITE_I;
            PINS.out_enable_n <= WRITE_I;
            PINS.host_data_oe <= WRITE_I;
          end
        end
        sbs_pkg::SBS_BURST: begin
          PINS.proc_addr_strobe_n <= 1'b1;
          PINS.ctrl_addr_strobe_n <= 1'b1;
          PINS.burst_advance_n <= 1'b0;
          // The device takes write data one clock after the address, so beat 0 stays two clocks.
          if (beat_q != 2'h0) begin
            wdata_q <= wdata_q + `SBS_DW'h1;
          end
          beat_q <= beat_q + 2'h1;
          if (beat_q == `SBS_BURST_LAST) begin
            state_q <= sbs_pkg::SBS_DESEL;
            PINS.burst_advance_n <= 1'b1;
            // Deselect cycle: strobe with first select high via controller strobe.
            PINS.first_select_n <= 1'b1;
            PINS.ctrl_addr_strobe_n <= 1'b0;
            PINS.write_n <= 1'b1;
          end
        end
        sbs_pkg::SBS_DESEL: begin
          // The last write word is taken on the deselect edge, so the lanes are released only now.
          PINS.host_data_oe <= 1'b0;
          PINS.ctrl_addr_strobe_n <= 1'b1;
          state_q <= sbs_pkg::SBS_DONE;
        end
        sbs_pkg::SBS_DONE: begin
          // Extra idle clocks cover the double-cycle deselect before release.
          if (rd_cnt_q == 3'h0) begin
            PINS.out_enable_n <= 1'b1;
            BUSY_O <= 1'b0;
            state_q <= sbs_pkg::SBS_IDLE;
          end
        end
        default: begin
          state_q <= sbs_pkg::SBS_IDLE;
        end
      endcase
    end
  end

  assign PINS.host_data_o = wdata_q;
  assign PINS.host_par_o = {`SBS_PW{^wdata_q}};

  // ------------------------------------------------------------
  // Read data capture
  // ------------------------------------------------------------
  // The device masks the first read word after a deselect, so the three later
  // words are taken from the last burst clock through the first idle clock.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_cnt_q <= 3'h0;
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
    end else begin
      RVALID_O <= !wr_q && BUSY_O && !PINS.out_enable_n && (state_q == sbs_pkg::SBS_DESEL
                  || (state_q == sbs_pkg::SBS_DONE && rd_cnt_q == `SBS_DESEL_HOLD)
                  || (state_q == sbs_pkg::SBS_BURST && beat_q == `SBS_BURST_LAST));
      RDATA_O <= PINS.data_lanes;
      if (state_q == sbs_pkg::SBS_DESEL) begin
        rd_cnt_q <= `SBS_DESEL_HOLD;
      end else if (rd_cnt_q != 3'h0) begin
        rd_cnt_q <= rd_cnt_q - 3'h1;
      end
    end
  end

endmodule

//--- tb/sbs_pins_chk.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Pin protocol checks between the device end and the host end
// ------------------------------------------------------------
module sbs_pins_chk (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic first_select_n,
  input wire logic second_select_hi,
  input wire logic third_select_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic write_n,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic dev_data_oe,
  input wire logic host_data_oe
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  logic load;
  logic sel;
  logic desel_q;

  // A processor strobe with the first select high is ignored, so it is no load.
  assign load = (!proc_addr_strobe_n && !first_select_n) || !ctrl_addr_strobe_n;
  assign sel = !first_select_n && second_select_hi && !third_select_n;

  // Remembers whether the last load deselected; reset counts as deselected.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      desel_q <= 1'h1;
    end else if (load) begin
      desel_q <= !sel;
    end
  end

  sequence burst_beats;
    (!burst_advance_n && proc_addr_strobe_n && ctrl_addr_strobe_n)[*3];
  endsequence
  sequence desel_strobe;
    (!proc_addr_strobe_n || !ctrl_addr_strobe_n) && !sel;
  endsequence

  a_no_contend: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data lanes");
  a_oe_release: assert property (out_enable_n [*4] |-> !dev_data_oe)
    else $error("device drives with output enable high");
  a_oe_drive: assert property (dev_data_oe |-> !$past(out_enable_n, 2) || !$past(out_enable_n, 3))
    else $error("device drive without output enable low");
  a_sleep_low: assert property (!sleep_request)
    else $error("sleep request raised");
  a_third_held: assert property (!third_select_n)
    else $error("third select left inactive");
  a_desel_hold: assert property (load && !sel && dev_data_oe |=> dev_data_oe ##1 !dev_data_oe)
    else $error("drive not held one clock after deselect");
  // The read word first stands one clock after the load, so both clocks must stay quiet.
  a_first_masked: assert property (load && sel && write_n && desel_q |=> !dev_data_oe [*2])
    else $error("first read clock after deselect drives");
  a_burst_walk: assert property (load && sel |=> burst_beats ##1 desel_strobe)
    else $error("burst walk broken");
endmodule

//--- tb/sync_burst_sram_control_pins_tb_top.sv
`timescale 1ns/1ps
`include "sbs_map.svh"

module sync_burst_sram_control_pins_tb_top;
  logic MCLK_I = 1'h0;
  logic RSTN_I = 1'h0;
  logic strap_n = 1'h0;
  logic req = 1'h0;
  logic wr = 1'h0;
  logic use_ctrl = 1'h0;
  logic [`SBS_AW-1:0] addr = '0;
  logic [`SBS_DW-1:0] wdata = '0;
  logic busy, rvalid, selected, sleeping;
  logic [`SBS_DW-1:0] rdata;
  logic [`SBS_DW-1:0] rq[$];
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  sbs_if pins ();

  always #10 MCLK_I = ~MCLK_I;

  sbs_device i_sbs_device (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .LINEAR_ORDER_N_I(strap_n),
    .SELECTED_O(selected), .SLEEPING_O(sleeping), .PINS(pins.device));
  sbs_host i_sbs_host (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .REQ_I(req), .WRITE_I(wr),
    .USE_CTRL_STROBE_I(use_ctrl), .ADDR_I(addr), .WDATA_I(wdata), .BUSY_O(busy),
    .RVALID_O(rvalid), .RDATA_O(rdata), .PINS(pins.host));
  sbs_pins_chk i_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .first_select_n(pins.first_select_n),
    .second_select_hi(pins.second_select_hi), .third_select_n(pins.third_select_n),
    .proc_addr_strobe_n(pins.proc_addr_strobe_n), .ctrl_addr_strobe_n(pins.ctrl_addr_strobe_n),
    .burst_advance_n(pins.burst_advance_n), .write_n(pins.write_n), .out_enable_n(pins.out_enable_n),
    .sleep_request(pins.sleep_request), .dev_data_oe(pins.dev_data_oe), .host_data_oe(pins.host_data_oe));

  // Collects read words and cuts a hang short well past the hundred or so clocks needed.
  always @(posedge MCLK_I) begin
    cycles++;
    if (RSTN_I && rvalid === 1'h1) rq.push_back(rdata);
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // The strap is only latched after reset, so each burst order needs its own reset.
  task automatic do_reset(input logic order_n);
    RSTN_I = 1'h0;
    strap_n = order_n;
    repeat (16) @(posedge MCLK_I);
    #1 RSTN_I = 1'h1;
    repeat (4) @(posedge MCLK_I);
    #1;
  endtask

  task automatic burst(input logic w, input logic c, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq.delete();
    wr = w;
    use_ctrl = c;
    addr = a;
    wdata = d;
    req = 1'h1;
    while (busy !== 1'h1 && n < 20) begin
      @(posedge MCLK_I);
      #1 n++;
    end
    req = 1'h0;
    // The select registers on the strobe edge and shows one clock after it.
    repeat (2) @(posedge MCLK_I);
    #1 check("selected", 32'h1, {31'h0, selected});
    while (busy !== 1'h0 && n < 40) begin
      @(posedge MCLK_I);
      #1 n++;
    end
    check("busy", 32'h0, {31'h0, busy});
    check("selected", 32'h0, {31'h0, selected});
    check("sleeping", 32'h0, {31'h0, sleeping});
  endtask

  // Words were written at base 0 of the line, so word value is its low address bits plus w.
  task automatic rd(input logic c, input logic [5:0] a, input logic order_n, input logic [31:0] w);
    logic [1:0] low;
    int k;
    burst(1'h0, c, a, 32'h0);
    // Four beats, of which the first after a deselect is never driven.
    check("beats", 32'h3, 32'(rq.size()));
    foreach (rq[i]) begin
      k = 4 - rq.size() + i;
      low = order_n ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
      check("rdata", w + 32'(low), rq[i]);
    end
  endtask

  initial begin
    do_reset(1'h0);
    burst(1'h1, 1'h0, 6'h04, 32'hA0000000);
    rd(1'h0, 6'h05, 1'h0, 32'hA0000000);
    rd(1'h1, 6'h07, 1'h0, 32'hA0000000);
    do_reset(1'h1);
    burst(1'h1, 1'h1, 6'h04, 32'hB0000000);
    rd(1'h1, 6'h06, 1'h1, 32'hB0000000);
    rd(1'h0, 6'h05, 1'h1, 32'hB0000000);
    end_sim();
  end
endmodule
